// File: verilog/nfcsp_pkg.sv
package nfcsp_pkg;

  // spi operation field values, top two bits of the operation byte
  localparam logic [1:0] OP_REG_WRITE = 2'h0;
  localparam logic [1:0] OP_REG_READ = 2'h1;
  localparam logic [1:0] OP_FIFO = 2'h2;
  localparam logic [1:0] OP_DIRECT = 2'h3;
  localparam logic [5:0] FIFO_LOAD_CODE = 6'h00;
  localparam logic [5:0] FIFO_READ_CODE = 6'h3F;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // spi-addressed registers implemented in this port
  localparam logic [5:0] SPI_IO_CFG2 = 6'h01;
  localparam logic [5:0] SPI_OP_CTRL = 6'h02;
  localparam logic [5:0] SPI_MAIN_IRQ = 6'h17;
  localparam int OP_CTRL_EN_BIT = 7;
  localparam int IO_CFG2_PD_A_BIT = 3;
  localparam int IO_CFG2_PD_B_BIT = 4;
  localparam int MAIN_IRQ_CMD_BIT = 0;
  localparam logic [7:0] IO_CFG2_RST = 8'h00;
  localparam logic [7:0] OP_CTRL_RST = 8'h00;

  // avalon register byte offsets
  localparam logic [3:0] AV_CTRL = 4'h0;
  localparam logic [3:0] AV_STATUS = 4'h4;
  localparam logic [3:0] AV_EVENT = 4'h8;
  localparam int CTRL_THR_LSB = 0;
  localparam int EVENT_DONE_BIT = 0;
  localparam logic [5:0] CTRL_THR_RST = 6'h20;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_EN_BIT = 1;
  localparam int STAT_IRQ_BIT = 2;
  localparam int STAT_CODE_LSB = 8;

  // mcu clock divider: half period in system clocks, minus one
  localparam logic [1:0] MCU_CLK_HALF = 2'h1;

  typedef enum logic [2:0] {
    NFCSP_ST_OP,
    NFCSP_ST_WR,
    NFCSP_ST_RD,
    NFCSP_ST_FLD,
    NFCSP_ST_FRD,
    NFCSP_ST_IGN
  } nfcsp_state_t;

endpackage

// File: verilog/nfcsp_port.sv
// Contract
// - select high holds the serial logic in reset; low enables it.
// - mosi is sampled on each falling sclk edge.
// - transfers are 8-bit bytes, most significant bit first.
// - first byte top bits pick write, read, fifo or direct command.
// - further register bytes target previous address plus one until deselect.
// - each write byte commits on the falling edge of its eighth bit.
// - a write byte cut short by deselect is dropped.
// - writes to missing or read-only registers change nothing.
// - miso changes on rising sclk; master captures on falling edge.
// - reads from unimplemented addresses return zero.
// - miso is tristated except while shifting out read data.
// - both pull-down bits set enable miso pull-down while tristated.
// - fifo load code 10 000000, each following byte goes to tx fifo.
// - a fifo load byte cut short by deselect is not stored.
// - fifo read code 10 111111 shifts fifo bytes out like register reads.
// - a fifo byte not fully shifted out stays unread for next read.
// - direct command code 11 starts on falling edge of last bit.
// - a lengthy command finishing raises the interrupt output.
// - after an immediate command a new operation byte may follow.
// - registers always reachable; fifo needs enable bit 7 and stable oscillator.
// - the port is only a slave; it requests service by interrupt.
// - a clock goes to the microcontroller while the oscillator runs.
// - interrupt sets main interrupt source bit and drives irq high.
`timescale 1ns/100ps
module nfcsp_port
  import nfcsp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // spi pins
  input wire logic ss_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo_out,
  output logic sdo_oe,
  output logic sdo_pulldown_en,
  output logic irq,
  // oscillator and mcu clock
  input wire logic osc_running,
  input wire logic xtal_stable,
  output logic mcu_clk,
  // fifo and command side
  output logic tx_push,
  output logic [7:0] tx_data,
  input wire logic [7:0] rx_data,
  output logic rx_pop,
  output logic cmd_start,
  output logic [5:0] command_field
);

  // register-bus and spi-side state
  logic [5:0] thr_ff;
  logic busy_ff;
  logic [7:0] io_cfg2_ff;
  logic [7:0] op_ctrl_ff;
  logic [7:0] main_irq_ff;
  logic av_ack_ff;
  logic [31:0] rdata_ff;
  logic [1:0] ss_sync_ff;
  logic [2:0] sclk_sync_ff;
  logic [1:0] sdi_sync_ff;
  nfcsp_state_t state_ff;
  nfcsp_state_t nxt_state;
  logic [2:0] bit_cnt_ff;
  logic [7:0] rx_sh_ff;
  logic [7:0] tx_sh_ff;
  logic [5:0] addr_ff;
  logic [5:0] nxt_addr;
  logic [1:0] div_cnt_ff;
  logic mcu_clk_ff;
  logic sdo_ff;
  logic oe_ff;
  logic tx_push_ff;
  logic [7:0] tx_data_ff;
  logic rx_pop_ff;
  logic frd_reload_ff;
  logic cmd_ff;
  logic [5:0] cmd_code_ff;
  logic sel;
  logic fall;
  logic rise;
  logic byte_done;
  logic [7:0] byte_in;
  logic fifo_ok;
  logic load_tx;
  logic [7:0] load_val;
  logic reg_wr;
  logic irq_read;
  logic cmd_long;
  logic done_evt;
  logic av_wr;

  // read-back of spi-addressed registers; missing ones give zero
  function automatic logic [7:0] reg_read(input logic [5:0] a, input logic [7:0] cfg,
                                          input logic [7:0] ctl, input logic [7:0] irqv);
    case (a)
      SPI_IO_CFG2: reg_read = cfg;
      SPI_OP_CTRL: reg_read = ctl;
      SPI_MAIN_IRQ: reg_read = irqv;
      default: reg_read = 8'h00;
    endcase
  endfunction

  // true for addresses software may write over spi
  function automatic logic reg_writable(input logic [5:0] a);
    reg_writable = (a == SPI_IO_CFG2) || (a == SPI_OP_CTRL);
  endfunction

  // two-flop synchronisers; stage 2 and 3 feed edge detection
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ss_sync_ff <= 2'h3;
      sclk_sync_ff <= 3'h0;
      sdi_sync_ff <= 2'h0;
    end
    else
    begin
      ss_sync_ff <= {ss_sync_ff[0], ss_n};
      sclk_sync_ff <= {sclk_sync_ff[1:0], sclk};
      sdi_sync_ff <= {sdi_sync_ff[0], sdi};
    end
  end

  // link edges, only while selected
  assign sel = ~ss_sync_ff[1];
  assign fall = sel & sclk_sync_ff[2] & ~sclk_sync_ff[1];
  assign rise = sel & ~sclk_sync_ff[2] & sclk_sync_ff[1];
  assign byte_done = fall & (bit_cnt_ff == LAST_BIT);
  assign byte_in = {rx_sh_ff[6:0], sdi_sync_ff[1]};
  assign fifo_ok = op_ctrl_ff[OP_CTRL_EN_BIT] & xtal_stable;
  assign cmd_long = byte_in[5:0] >= thr_ff;

  // bit counter and input shifter, msb first on falling sclk
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bit_cnt_ff <= 3'h0;
      rx_sh_ff <= 8'h00;
    end
    else if (!sel)
      bit_cnt_ff <= 3'h0;
    else if (fall)
    begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      rx_sh_ff <= byte_in;
    end
  end

  // operation decoder and data phase sequencing
  always_comb
  begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    load_tx = 1'b0;
    load_val = 8'h00;
    reg_wr = 1'b0;
    irq_read = 1'b0;
    if (byte_done)
    begin
      case (state_ff)
        NFCSP_ST_OP:
        begin
          nxt_addr = byte_in[5:0];
          case (byte_in[7:6])
            OP_REG_WRITE: nxt_state = NFCSP_ST_WR;
            OP_REG_READ:
            begin
              nxt_state = NFCSP_ST_RD;
              load_tx = 1'b1;
              load_val = reg_read(byte_in[5:0], io_cfg2_ff, op_ctrl_ff, main_irq_ff);
              irq_read = byte_in[5:0] == SPI_MAIN_IRQ;
              nxt_addr = byte_in[5:0] + 6'h01;
            end
            OP_FIFO:
            begin
              if (fifo_ok && byte_in[5:0] == FIFO_LOAD_CODE)
                nxt_state = NFCSP_ST_FLD;
              else if (fifo_ok && byte_in[5:0] == FIFO_READ_CODE)
              begin
                nxt_state = NFCSP_ST_FRD;
                load_tx = 1'b1;
                load_val = rx_data;
              end
              else
                nxt_state = NFCSP_ST_IGN;
            end
            OP_DIRECT: nxt_state = cmd_long ? NFCSP_ST_IGN : NFCSP_ST_OP;
            default: nxt_state = NFCSP_ST_IGN;
          endcase
        end
        NFCSP_ST_WR:
        begin
          reg_wr = reg_writable(addr_ff);
          nxt_addr = addr_ff + 6'h01;
        end
        NFCSP_ST_RD:
        begin
          load_tx = 1'b1;
          load_val = reg_read(addr_ff, io_cfg2_ff, op_ctrl_ff, main_irq_ff);
          irq_read = addr_ff == SPI_MAIN_IRQ;
          nxt_addr = addr_ff + 6'h01;
        end
        default: nxt_state = state_ff;
      endcase
    end
  end

  // state and address registers; deselect clears only the state
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= NFCSP_ST_OP;
      addr_ff <= 6'h00;
    end
    else if (!sel)
      state_ff <= NFCSP_ST_OP;
    else
    begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
    end
  end

  // output shifter: loaded at byte end, shifted out on rising sclk
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_sh_ff <= 8'h00;
      sdo_ff <= 1'b0;
      oe_ff <= 1'b0;
    end
    else if (!sel)
    begin
      oe_ff <= 1'b0;
      sdo_ff <= 1'b0;
    end
    else if (load_tx)
      tx_sh_ff <= load_val;
    else if (frd_reload_ff)
      tx_sh_ff <= rx_data; // fifo head as it stands after the pop
    else if (rise && (state_ff == NFCSP_ST_RD || state_ff == NFCSP_ST_FRD))
    begin
      sdo_ff <= tx_sh_ff[7];
      tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
      oe_ff <= 1'b1;
    end
  end

  // one-cycle strobes toward fifo and command logic
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_push_ff <= 1'b0;
      tx_data_ff <= 8'h00;
      rx_pop_ff <= 1'b0;
      cmd_ff <= 1'b0;
      cmd_code_ff <= 6'h00;
      frd_reload_ff <= 1'b0;
    end
    else
    begin
      tx_push_ff <= byte_done && state_ff == NFCSP_ST_FLD;
      rx_pop_ff <= byte_done && state_ff == NFCSP_ST_FRD;
      frd_reload_ff <= rx_pop_ff; // the popped head is replaced one cycle later
      cmd_ff <= byte_done && state_ff == NFCSP_ST_OP && byte_in[7:6] == OP_DIRECT;
      if (byte_done && state_ff == NFCSP_ST_FLD)
        tx_data_ff <= byte_in;
      if (byte_done && state_ff == NFCSP_ST_OP && byte_in[7:6] == OP_DIRECT)
        cmd_code_ff <= byte_in[5:0];
    end
  end

  // spi-writable configuration registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      io_cfg2_ff <= IO_CFG2_RST;
      op_ctrl_ff <= OP_CTRL_RST;
    end
    else if (reg_wr)
    begin
      if (addr_ff == SPI_IO_CFG2)
        io_cfg2_ff <= byte_in;
      if (addr_ff == SPI_OP_CTRL)
        op_ctrl_ff <= byte_in;
    end
  end

  // lengthy command tracking and interrupt source bit
  assign done_evt = av_wr && avs_address == AV_EVENT && avs_writedata[EVENT_DONE_BIT];
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_ff <= 1'b0;
      main_irq_ff <= 8'h00;
    end
    else
    begin
      if (byte_done && state_ff == NFCSP_ST_OP && byte_in[7:6] == OP_DIRECT && cmd_long)
        busy_ff <= 1'b1;
      else if (done_evt)
        busy_ff <= 1'b0;
      if (done_evt && busy_ff)
        main_irq_ff[MAIN_IRQ_CMD_BIT] <= 1'b1;
      else if (irq_read)
        main_irq_ff <= 8'h00; // clear on read, a new event wins
    end
  end

  // microcontroller clock, runs only with the oscillator
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_cnt_ff <= 2'h0;
      mcu_clk_ff <= 1'b0;
    end
    else if (!osc_running)
    begin
      div_cnt_ff <= 2'h0;
      mcu_clk_ff <= 1'b0;
    end
    else if (div_cnt_ff == MCU_CLK_HALF)
    begin
      div_cnt_ff <= 2'h0;
      mcu_clk_ff <= ~mcu_clk_ff;
    end
    else
      div_cnt_ff <= div_cnt_ff + 2'h1;
  end

  // avalon slave: one wait state, then answer
  assign av_wr = avs_write & av_ack_ff;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      av_ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      thr_ff <= CTRL_THR_RST;
    end
    else
    begin
      av_ack_ff <= (avs_read | avs_write) & ~av_ack_ff;
      if (av_wr && avs_address == AV_CTRL)
        thr_ff <= avs_writedata[CTRL_THR_LSB +: 6];
      if ((avs_read | avs_write) && !av_ack_ff)
      begin
        rdata_ff <= 32'h0000_0000;
        case (avs_address)
          AV_CTRL: rdata_ff[CTRL_THR_LSB +: 6] <= thr_ff;
          AV_STATUS:
          begin
            rdata_ff[STAT_BUSY_BIT] <= busy_ff;
            rdata_ff[STAT_EN_BIT] <= op_ctrl_ff[OP_CTRL_EN_BIT];
            rdata_ff[STAT_IRQ_BIT] <= irq;
            rdata_ff[STAT_CODE_LSB +: 6] <= cmd_code_ff;
          end
          default: rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // output drives
  assign avs_waitrequest = (avs_read | avs_write) & ~av_ack_ff;
  assign avs_readdata = rdata_ff;
  assign sdo_out = sdo_ff;
  assign sdo_oe = oe_ff;
  assign sdo_pulldown_en = ~oe_ff & (&io_cfg2_ff[IO_CFG2_PD_B_BIT:IO_CFG2_PD_A_BIT]);
  assign irq = |main_irq_ff;
  assign mcu_clk = mcu_clk_ff;
  assign tx_push = tx_push_ff;
  assign tx_data = tx_data_ff;
  assign rx_pop = rx_pop_ff;
  assign cmd_start = cmd_ff;
  assign command_field = cmd_code_ff;

endmodule

// File: sim/nfcsp_port_checker.sv
`timescale 1ns/100ps
module nfcsp_port_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ss_n,
  input wire logic sclk,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic sdo_pulldown_en,
  input wire logic osc_running,
  input wire logic mcu_clk,
  input wire logic tx_push,
  input wire logic rx_pop,
  input wire logic cmd_start,
  input wire logic [5:0] command_field
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // select held high long enough for the synchroniser to settle
  sequence s_idle;
    ss_n [*5];
  endsequence
  sequence s_osc_off;
    !osc_running [*2];
  endsequence

  // strobes, output enable and clock output relations
  property p_idle_quiet;
    s_idle |-> !tx_push && !rx_pop && !cmd_start;
  endproperty
  property p_oe_off;
    s_idle |-> !sdo_oe;
  endproperty
  property p_pd_tristate;
    sdo_pulldown_en |-> !sdo_oe;
  endproperty
  property p_cmd_pulse;
    cmd_start |=> !cmd_start && $stable(command_field);
  endproperty
  property p_push_pulse;
    tx_push |=> !tx_push;
  endproperty
  property p_pop_pulse;
    rx_pop |=> !rx_pop;
  endproperty
  property p_sdo_on_rise;
    $past(sdo_oe) && sdo_oe && $changed(sdo_out) |-> sclk;
  endproperty
  property p_mcu_off;
    s_osc_off |-> !mcu_clk;
  endproperty

  a_idle_quiet: assert property (p_idle_quiet)
    else $error("strobe while deselected");
  a_oe_off: assert property (p_oe_off)
    else $error("sdo driven while deselected");
  a_pd_tristate: assert property (p_pd_tristate)
    else $error("pull-down while driving");
  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("command strobe too long or code moved");
  a_push_pulse: assert property (p_push_pulse)
    else $error("push strobe too long");
  a_pop_pulse: assert property (p_pop_pulse)
    else $error("pop strobe too long");
  a_sdo_on_rise: assert property (p_sdo_on_rise)
    else $error("sdo changed while sclk low");
  a_mcu_off: assert property (p_mcu_off)
    else $error("clock output without oscillator");
endmodule

bind nfcsp_port nfcsp_port_checker nfcsp_port_checker_inst (.clk(clk), .arst_n(arst_n),
  .ss_n(ss_n), .sclk(sclk), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
  .sdo_pulldown_en(sdo_pulldown_en), .osc_running(osc_running), .mcu_clk(mcu_clk),
  .tx_push(tx_push), .rx_pop(rx_pop), .cmd_start(cmd_start), .command_field(command_field));

// File: sim/nfcsp_spi_master.sv
`timescale 1ns/100ps
module nfcsp_spi_master (
  output logic ss_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic sdo_pulldown_en
);
  logic last_sdo;
  wire miso;

  // released line: pull-down when enabled, else inverse of the last bit
  assign miso = sdo_oe ? sdo_out : (sdo_pulldown_en ? 1'b0 : ~last_sdo);
  always @(negedge sdo_oe)
    last_sdo = sdo_out;

  // idle: deselected, link clock still
  initial
  begin
    ss_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    last_sdo = 1'b0;
  end

  // only this master opens a frame
  task start;
    ss_n = 1'b0;
    #32;
  endtask

  task stop;
    #32;
    ss_n = 1'b1;
    sdi = ~sdi;
    #200;
  endtask

  // n bits of one byte, msb first, capture on the falling edge
  task xfer(input logic [7:0] d, input int n, output logic [7:0] q);
    q = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      #16 sdi = d[i];
      #16 sclk = 1'b1;
      #32 q[i] = miso;
      sclk = 1'b0;
    end
  endtask
endmodule

// File: sim/test_nfcsp_port.sv
`timescale 1ns/100ps
module test_nfcsp_port;
  import nfcsp_pkg::*;
  logic clk, arst_n, avs_read, avs_write, ss_n, sclk, sdi, osc_running, xtal_stable;
  logic avs_waitrequest, sdo_out, sdo_oe, sdo_pulldown_en, irq, mcu_clk;
  logic tx_push, rx_pop, cmd_start;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0] tx_data, rx_data, rx_base, r, v, last_tx;
  logic [5:0] command_field, c;
  int num_errors, checks, seed, n_push, n_pop, n_cmd;

  nfcsp_port nfcsp_port_inst (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ss_n(ss_n),
    .sclk(sclk), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .sdo_pulldown_en(sdo_pulldown_en), .irq(irq), .osc_running(osc_running),
    .xtal_stable(xtal_stable), .mcu_clk(mcu_clk), .tx_push(tx_push), .tx_data(tx_data),
    .rx_data(rx_data), .rx_pop(rx_pop), .cmd_start(cmd_start), .command_field(command_field));
  nfcsp_spi_master pm (.ss_n(ss_n), .sclk(sclk), .sdi(sdi), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .sdo_pulldown_en(sdo_pulldown_en));

  // 200 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // avalon access held until waitrequest is sampled low at a rising edge
  task av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // receive fifo model: head follows the base until the first pop, then steps
  always @(posedge clk)
  begin
    if (rx_pop === 1'b1)
      rx_data <= rx_data + 8'h11;
    else if (n_pop == 0)
      rx_data <= rx_base;
  end

  // count strobes of the fifo and command side mid-cycle
  always @(negedge clk)
  begin
    n_push += (tx_push === 1'b1);
    n_pop += (rx_pop === 1'b1);
    n_cmd += (cmd_start === 1'b1);
    if (tx_push === 1'b1)
      last_tx = tx_data;
  end

  // watchdog against a hang
  initial
  begin
    #200000;
    num_errors++;
    print_verdict;
  end

  initial
  begin
    seed = 13;
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    osc_running = 1'b1;
    xtal_stable = 1'b1;
    rx_base = 8'h00;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    av(1'b0, AV_CTRL, 32'h0);
    chk(q, {26'h0, CTRL_THR_RST});
    av(1'b1, AV_CTRL, 32'h30);
    av(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    // burst write, then a cut byte, then a read-only target
    pm.start();
    pm.xfer({OP_REG_WRITE, SPI_IO_CFG2}, 8, r);
    pm.xfer(8'h18, 8, r);
    pm.xfer(8'h80, 8, r);
    pm.stop();
    pm.start();
    pm.xfer({OP_REG_WRITE, SPI_IO_CFG2}, 8, r);
    pm.xfer(8'h00, 5, r);
    pm.stop();
    pm.start();
    pm.xfer({OP_REG_WRITE, SPI_MAIN_IRQ}, 8, r);
    pm.xfer(8'hFF, 8, r);
    pm.stop();
    chk(irq, 1'b0);
    // burst read across into an unmapped address
    pm.start();
    pm.xfer({OP_REG_READ, SPI_IO_CFG2}, 8, r);
    pm.xfer(8'h00, 8, r);
    chk(r, 8'h18);
    pm.xfer(8'h00, 8, r);
    chk(r, 8'h80);
    pm.xfer(8'h00, 8, r);
    chk(r, 8'h00);
    pm.stop();
    chk(sdo_pulldown_en, 1'b1);
    // immediate command chained with a fifo load, last byte cut short
    for (int k = 0; k < 4; k++)
    begin
      c = (k == 0) ? 6'h2F : 6'((($random(seed)) & 32'h7FFFFFFF) % 48);
      v = 8'($random(seed));
      pm.start();
      pm.xfer({OP_DIRECT, c}, 8, r);
      pm.xfer({OP_FIFO, FIFO_LOAD_CODE}, 8, r);
      pm.xfer(v, 8, r);
      pm.xfer(~v, 6, r);
      pm.stop();
      chk(command_field, c);
      chk(last_tx, v);
    end
    chk(n_push, 4);
    chk(n_cmd, 4);
    // fifo read: two full bytes and a partial one, then the cut byte again
    @(posedge clk);
    rx_base <= 8'($random(seed));
    pm.start();
    pm.xfer({OP_FIFO, FIFO_READ_CODE}, 8, r);
    pm.xfer(8'h00, 8, r);
    chk(r, rx_base);
    pm.xfer(8'h00, 8, r);
    chk(r, 8'(rx_base + 8'h11));
    pm.xfer(8'h00, 3, r);
    pm.stop();
    chk(n_pop, 2);
    pm.start();
    pm.xfer({OP_FIFO, FIFO_READ_CODE}, 8, r);
    pm.xfer(8'h00, 8, r);
    pm.stop();
    chk(r, 8'(rx_base + 8'h22));
    chk(n_pop, 3);
    // fifo refused once the enable bit is cleared
    pm.start();
    pm.xfer({OP_REG_WRITE, SPI_OP_CTRL}, 8, r);
    pm.xfer(8'h00, 8, r);
    pm.stop();
    pm.start();
    pm.xfer({OP_FIFO, FIFO_LOAD_CODE}, 8, r);
    pm.xfer(8'h5A, 8, r);
    pm.stop();
    chk(n_push, 4);
    @(posedge clk);
    osc_running <= 1'b0;
    repeat (4) @(posedge clk);
    chk(mcu_clk, 1'b0);
    osc_running <= 1'b1;
    repeat (4) @(negedge clk);
    v[0] = mcu_clk;
    repeat (2) @(negedge clk);
    chk(mcu_clk, !v[0]);
    // lengthy command at the threshold; no traffic until it ends
    pm.start();
    pm.xfer({OP_DIRECT, 6'h30}, 8, r);
    pm.stop();
    av(1'b0, AV_STATUS, 32'h0);
    chk(q[STAT_BUSY_BIT], 1'b1);
    chk(q[STAT_CODE_LSB +: 6], 6'h30);
    av(1'b1, AV_EVENT, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    pm.start();
    pm.xfer({OP_REG_READ, SPI_MAIN_IRQ}, 8, r);
    pm.xfer(8'h00, 8, r);
    pm.stop();
    chk(r[MAIN_IRQ_CMD_BIT], 1'b1);
    chk(irq, 1'b0);
    print_verdict;
  end
endmodule
